// *** rtl/ckd_pkg.sv ***
package ckd_pkg;
    // register map: byte-wide registers on a plain port
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFF_CLK_CTRL = 4'h0; // system_clock_control
    localparam logic [3:0] OFF_STATUS = 4'h1; // reset cause, sleep, current divider
    localparam logic [3:0] OFF_WDT_CTRL = 4'h2; // watchdog enable, kick
    localparam logic [3:0] OFF_WDT_LO = 4'h3; // watchdog count low byte
    localparam logic [3:0] OFF_WDT_HI = 4'h4; // watchdog count high byte
    localparam logic [3:0] OFF_RCCAL = 4'h5; // fast rc oscillator calibration
    localparam logic [3:0] OFF_SLEEP = 4'h6; // deep sleep entry, wake
    // field positions in system_clock_control
    localparam int TICK_LSB = 3;
    localparam int CLK_LSB = 0;
    // reset values
    localparam logic [2:0] TICK_RST = 3'h1;
    localparam logic [2:0] CLK_RST = 3'h1;
    localparam logic [7:0] RCCAL_RST = 8'h80;
    localparam logic [14:0] WDT_CLR = 15'h0000;
    localparam logic [15:0] PC_RST = 16'h0000;
    // external data space retention window
    localparam logic [15:0] RET_LO = 16'hF000;
    localparam logic [15:0] RET_HI = 16'hFFFF;
    localparam logic [15:0] LOST_LO = 16'hFDA2;
    localparam logic [15:0] LOST_HI = 16'hFEFF;
    // reset cause codes
    typedef enum logic [1:0] {
        CKD_CAUSE_POR,
        CKD_CAUSE_PIN,
        CKD_CAUSE_WDT
    } ckd_cause_e;
    // power states
    typedef enum logic [1:0] {
        CKD_ACTIVE,
        CKD_SLEEP_LOW,
        CKD_SLEEP_LOWEST
    } ckd_pwr_e;
endpackage : ckd_pkg

// *** rtl/ckd_top.sv ***
`timescale 1ns/10ps
// Notes on behaviour
// - both divider codes select reference divided by two to the code power
// - timers 1 to 4 share one tick enable pulse, not a gated clock
// - tick rate spans reference over 128 up to reference itself
// - external data 0xF000 to 0xFDA1 and 0xFF00 to 0xFFFF survives both deep sleep modes
// - external data 0xFDA2 to 0xFEFF is lost in deep sleep
// - registers keep values across deep sleep unless stated otherwise
// - entering deep sleep clears the watchdog counter to zero
// - waking from deep sleep restores the default rc calibration
// - reset comes from pin, power-on, brown-out or watchdog timeout
// - after reset the program counter starts at 0x0000
// - after reset pins are pulled-up inputs except two unpulled pins
// - after reset all registers take their defined reset values, except the cause register, which a watchdog reset leaves alone
// - after reset the watchdog stays disabled until software enables it
module ckd_top #(
    parameter int NUM_PINS = 8,
    parameter int UNPULLED_A = 0,
    parameter int UNPULLED_B = 1
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // reset sources
    input wire logic i_por,
    input wire logic i_brown_out,
    // register port
    input wire logic [ckd_pkg::ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // clock and tick outputs
    output logic o_sys_clk_en,
    output logic o_timer_tick,
    // reset outputs
    output logic o_core_rst_b,
    output logic [15:0] o_pc_reset_value,
    output logic [NUM_PINS-1:0] o_pin_pullup_en,
    output logic [NUM_PINS-1:0] o_pin_dir_out,
    // retention
    input wire logic [15:0] i_xaddr,
    output logic o_xaddr_retained,
    output logic o_deep_sleep,
    output logic [7:0] o_rc_cal
);
    // parameter sanity: both unpulled pins must be distinct places in the pin vector
    if (NUM_PINS < 2 || UNPULLED_A < 0 || UNPULLED_B < 0 || UNPULLED_A >= NUM_PINS
        || UNPULLED_B >= NUM_PINS || UNPULLED_A == UNPULLED_B) begin : g_bad_pins
        $error("ckd_top: bad pin parameters");
    end

    // reset release synchroniser, pin and power sources combined
    logic rst_src_b;
    logic rst_m_reg;
    logic rst_b_reg;
    logic wdt_fire;
    assign rst_src_b = i_rst_b & ~i_por & ~i_brown_out;
    always_ff @(posedge i_ref_clk or negedge rst_src_b) begin
        if (!rst_src_b) begin
            rst_m_reg <= 1'b0;
            rst_b_reg <= 1'b0;
        end else begin
            rst_m_reg <= 1'b1;
            rst_b_reg <= rst_m_reg;
        end
    end
    // watchdog timeout resets everything but the cause record; the pulse comes
    // from a flop so the cause register sees the timeout before the reset hits
    logic core_rst_b;
    logic wdt_rst_reg, wdt_rst_next;
    assign core_rst_b = rst_b_reg & ~wdt_rst_reg;

    // cause register survives watchdog resets only
    ckd_pkg::ckd_cause_e cause_reg, cause_next;
    logic por_seen_reg, por_seen_next;
    logic pwr_seen_reg, pwr_seen_next;
    logic pwr_rst_b;
    assign pwr_rst_b = ~i_por & ~i_brown_out;
    always_comb begin
        cause_next = cause_reg;
        por_seen_next = 1'b1;
        wdt_rst_next = wdt_fire;
        pwr_seen_next = pwr_seen_reg;
        // a pin held low inside a reset marks the pin as the latest source
        if (!rst_b_reg && !i_rst_b) begin
            pwr_seen_next = 1'b0;
        end
        if (!por_seen_reg) begin
            cause_next = pwr_seen_reg ? ckd_pkg::CKD_CAUSE_POR : ckd_pkg::CKD_CAUSE_PIN;
        end else if (wdt_fire) begin
            cause_next = ckd_pkg::CKD_CAUSE_WDT;
        end
    end
    always_ff @(posedge i_ref_clk or negedge rst_b_reg) begin
        if (!rst_b_reg) begin
            cause_reg <= ckd_pkg::CKD_CAUSE_POR;
            por_seen_reg <= 1'b0;
            wdt_rst_reg <= 1'b0;
        end else begin
            cause_reg <= cause_next;
            por_seen_reg <= por_seen_next;
            wdt_rst_reg <= wdt_rst_next;
        end
    end
    // power-on and brown-out leave their own mark, held while they last
    always_ff @(posedge i_ref_clk or negedge pwr_rst_b) begin
        if (!pwr_rst_b) begin
            pwr_seen_reg <= 1'b1;
        end else begin
            pwr_seen_reg <= pwr_seen_next;
        end
    end

    // control registers
    logic [2:0] tick_sel_reg, tick_sel_next;
    logic [2:0] clk_sel_reg, clk_sel_next;
    logic [2:0] clk_cur_reg, clk_cur_next;
    logic wdt_en_reg, wdt_en_next;
    logic [14:0] wdt_cnt_reg, wdt_cnt_next;
    logic [7:0] rc_cal_reg, rc_cal_next;
    ckd_pkg::ckd_pwr_e pwr_reg, pwr_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [6:0] div_reg, div_next;
    logic wr_clk, wr_wdt, wr_cal, wr_sleep;
    assign wr_clk = i_wr && i_addr == ckd_pkg::OFF_CLK_CTRL;
    assign wr_wdt = i_wr && i_addr == ckd_pkg::OFF_WDT_CTRL;
    assign wr_cal = i_wr && i_addr == ckd_pkg::OFF_RCCAL;
    assign wr_sleep = i_wr && i_addr == ckd_pkg::OFF_SLEEP;
    assign wdt_fire = wdt_en_reg && (&wdt_cnt_reg);

    // divider period end for a power-of-two code
    function automatic logic div_hit(input logic [6:0] cnt, input logic [2:0] code);
        logic [6:0] mask;
        mask = 7'(({7'h00, 1'b1} << code) - 8'h01);
        return (cnt & mask) == mask;
    endfunction : div_hit

    always_comb begin
        tick_sel_next = tick_sel_reg;
        clk_sel_next = clk_sel_reg;
        clk_cur_next = clk_cur_reg;
        wdt_en_next = wdt_en_reg;
        wdt_cnt_next = wdt_cnt_reg;
        rc_cal_next = rc_cal_reg;
        pwr_next = pwr_reg;
        rdata_next = 8'h00;
        div_next = 7'(div_reg + 7'h01);
        if (wr_clk) begin
            tick_sel_next = i_wdata[ckd_pkg::TICK_LSB +: 3];
            clk_sel_next = i_wdata[ckd_pkg::CLK_LSB +: 3];
        end
        // new system divider applies at a period boundary of the old one
        if (div_hit(div_reg, clk_cur_reg)) begin
            clk_cur_next = clk_sel_reg;
        end
        if (wr_wdt) begin
            if (i_wdata[0]) begin
                wdt_en_next = 1'b1;
            end
            if (i_wdata[1]) begin
                wdt_cnt_next = ckd_pkg::WDT_CLR;
            end
        end else if (wdt_en_reg && pwr_reg == ckd_pkg::CKD_ACTIVE) begin
            wdt_cnt_next = 15'(wdt_cnt_reg + 15'h0001);
        end
        if (wr_cal) begin
            rc_cal_next = i_wdata;
        end
        // deep sleep entry and wake; other state is kept as is
        unique case (pwr_reg)
            ckd_pkg::CKD_ACTIVE: begin
                if (wr_sleep && i_wdata[1:0] != 2'h0) begin
                    pwr_next = i_wdata[0] ? ckd_pkg::CKD_SLEEP_LOW
                                          : ckd_pkg::CKD_SLEEP_LOWEST;
                    wdt_cnt_next = ckd_pkg::WDT_CLR;
                end
            end
            ckd_pkg::CKD_SLEEP_LOW, ckd_pkg::CKD_SLEEP_LOWEST: begin
                if (wr_sleep && i_wdata[1:0] == 2'h0) begin
                    pwr_next = ckd_pkg::CKD_ACTIVE;
                    rc_cal_next = ckd_pkg::RCCAL_RST;
                end
            end
            default: pwr_next = ckd_pkg::CKD_ACTIVE;
        endcase
        if (i_rd) begin
            unique case (i_addr)
                ckd_pkg::OFF_CLK_CTRL: rdata_next = {2'h0, tick_sel_reg, clk_sel_reg};
                ckd_pkg::OFF_STATUS: rdata_next = {pwr_reg, cause_reg, 1'b0, clk_cur_reg};
                ckd_pkg::OFF_WDT_CTRL: rdata_next = {7'h00, wdt_en_reg};
                ckd_pkg::OFF_WDT_LO: rdata_next = wdt_cnt_reg[7:0];
                ckd_pkg::OFF_WDT_HI: rdata_next = {1'b0, wdt_cnt_reg[14:8]};
                ckd_pkg::OFF_RCCAL: rdata_next = rc_cal_reg;
                ckd_pkg::OFF_SLEEP: rdata_next = {6'h00, pwr_reg};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // every register in this block takes its reset value on any reset source
    always_ff @(posedge i_ref_clk or negedge core_rst_b) begin
        if (!core_rst_b) begin
            tick_sel_reg <= ckd_pkg::TICK_RST;
            clk_sel_reg <= ckd_pkg::CLK_RST;
            clk_cur_reg <= ckd_pkg::CLK_RST;
            wdt_en_reg <= 1'b0;
            wdt_cnt_reg <= ckd_pkg::WDT_CLR;
            rc_cal_reg <= ckd_pkg::RCCAL_RST;
            pwr_reg <= ckd_pkg::CKD_ACTIVE;
            rdata_reg <= 8'h00;
            div_reg <= 7'h00;
        end else begin
            tick_sel_reg <= tick_sel_next;
            clk_sel_reg <= clk_sel_next;
            clk_cur_reg <= clk_cur_next;
            wdt_en_reg <= wdt_en_next;
            wdt_cnt_reg <= wdt_cnt_next;
            rc_cal_reg <= rc_cal_next;
            pwr_reg <= pwr_next;
            rdata_reg <= rdata_next;
            div_reg <= div_next;
        end
    end

    // tick and system clock enables: one cycle per divided period
    logic tick_reg, tick_next, sys_en_reg, sys_en_next;
    always_comb begin
        tick_next = div_hit(div_reg, tick_sel_reg);
        sys_en_next = div_hit(div_reg, clk_cur_reg);
    end
    always_ff @(posedge i_ref_clk or negedge core_rst_b) begin
        if (!core_rst_b) begin
            tick_reg <= 1'b0;
            sys_en_reg <= 1'b0;
        end else begin
            tick_reg <= tick_next;
            sys_en_reg <= sys_en_next;
        end
    end

    // reset state of pins and core
    logic [NUM_PINS-1:0] pull_mask;
    always_comb begin
        pull_mask = '1;
        pull_mask[UNPULLED_A] = 1'b0;
        pull_mask[UNPULLED_B] = 1'b0;
    end
    assign o_pin_pullup_en = pull_mask;
    assign o_pin_dir_out = '0;
    assign o_pc_reset_value = ckd_pkg::PC_RST;
    assign o_core_rst_b = core_rst_b;
    assign o_rdata = rdata_reg;
    assign o_timer_tick = tick_reg;
    assign o_sys_clk_en = sys_en_reg;
    assign o_rc_cal = rc_cal_reg;
    assign o_deep_sleep = pwr_reg != ckd_pkg::CKD_ACTIVE;
    // retained external data flag for the memory power switch
    assign o_xaddr_retained = i_xaddr >= ckd_pkg::RET_LO && i_xaddr <= ckd_pkg::RET_HI
        && !(i_xaddr >= ckd_pkg::LOST_LO && i_xaddr <= ckd_pkg::LOST_HI);

    // checks
    sequence s_sleep_entry;
        pwr_reg == ckd_pkg::CKD_ACTIVE && wr_sleep && i_wdata[1:0] != 2'h0;
    endsequence
    sequence s_wake;
        pwr_reg != ckd_pkg::CKD_ACTIVE && wr_sleep && i_wdata[1:0] == 2'h0;
    endsequence
    chk_tick_one_cycle: assert property (@(posedge i_ref_clk) disable iff (!core_rst_b)
        o_timer_tick && tick_sel_reg != 3'h0 && $stable(tick_sel_reg) && !wr_clk
        |=> !o_timer_tick)
        else $error("tick longer than one cycle");
    chk_tick_period_two: assert property (@(posedge i_ref_clk) disable iff (!core_rst_b)
        tick_sel_reg == 3'h1 && $stable(tick_sel_reg) && o_timer_tick |=> ##1 o_timer_tick)
        else $error("tick period wrong for code one");
    chk_tick_full_rate: assert property (@(posedge i_ref_clk) disable iff (!core_rst_b)
        tick_sel_reg == 3'h0 && $past(tick_sel_reg) == 3'h0 |=> o_timer_tick)
        else $error("undivided tick missing");
    chk_wdt_sleep_clr: assert property (@(posedge i_ref_clk) disable iff (!core_rst_b)
        s_sleep_entry |=> wdt_cnt_reg == 15'h0000 && o_deep_sleep)
        else $error("watchdog not cleared on sleep");
    chk_cal_wake: assert property (@(posedge i_ref_clk) disable iff (!core_rst_b)
        s_wake |=> o_rc_cal == ckd_pkg::RCCAL_RST && !o_deep_sleep)
        else $error("calibration not restored on wake");
    chk_wdt_off_reset: assert property (@(posedge i_ref_clk) disable iff (!core_rst_b)
        $rose(core_rst_b) |-> !wdt_en_reg)
        else $error("watchdog enabled after reset");
    chk_lost_range: assert property (@(posedge i_ref_clk) disable iff (!core_rst_b)
        i_xaddr >= 16'hFDA2 && i_xaddr <= 16'hFEFF |-> !o_xaddr_retained)
        else $error("lost range marked retained");
    chk_retain_range: assert property (@(posedge i_ref_clk) disable iff (!core_rst_b)
        i_xaddr == 16'hF000 || i_xaddr == 16'hFFFF || i_xaddr == 16'hFDA1 |-> o_xaddr_retained)
        else $error("retained range missed");
    chk_sleep_keeps: assert property (@(posedge i_ref_clk) disable iff (!core_rst_b)
        s_sleep_entry |=> tick_sel_reg == $past(tick_sel_reg) && rc_cal_reg == $past(rc_cal_reg))
        else $error("state lost on sleep entry");
    chk_wdt_cause: assert property (@(posedge i_ref_clk) disable iff (!rst_b_reg)
        wdt_fire |=> cause_reg == ckd_pkg::CKD_CAUSE_WDT && !o_core_rst_b)
        else $error("watchdog timeout did not reset the core");
    chk_pins_reset: assert property (@(posedge i_ref_clk) disable iff (!core_rst_b)
        !o_pin_pullup_en[UNPULLED_A] && o_pin_dir_out == '0)
        else $error("pin reset state wrong");
endmodule : ckd_top

// *** sim/ckd_periph_model.sv ***
`timescale 1ns/10ps
// timers 1 to 4 and the cpu core as seen from the clock block
module ckd_periph_model (
    // clock and core reset
    input wire logic i_ref_clk,
    input wire logic i_core_rst_b,
    // enables from the clock block
    input wire logic i_tick,
    input wire logic i_sys_en,
    // observed counts
    output int o_ticks,
    output int o_cycles,
    output int o_resets
);
    // unpulled pins are left to board pulls, never read here
    initial begin
        o_ticks = 0;
        o_cycles = 0;
        o_resets = 0;
    end
    // timers advance once per tick enable on the free running clock
    always @(posedge i_ref_clk) begin
        if (i_core_rst_b === 1'b1 && i_tick === 1'b1) begin
            o_ticks <= o_ticks + 1;
        end
        if (i_core_rst_b === 1'b1 && i_sys_en === 1'b1) begin
            o_cycles <= o_cycles + 1;
        end
    end
    // core sees every reset pulse, however short
    always @(negedge i_core_rst_b) begin
        o_resets <= o_resets + 1;
    end
endmodule : ckd_periph_model

// *** sim/clock_divider_tick_and_reset_tb_top.sv ***
`timescale 1ns/10ps
module clock_divider_tick_and_reset_tb_top;
    logic ref_clk, rst_b, por, bod, wr, rd, sys_en, tick, core_rst_b, retained, deep;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, rc_cal, pull, dir, rd_val;
    logic [15:0] pc, xaddr;
    int ticks, cycles, resets, miscompares, n_tests;
    int mdl [16];

    // 40 MHz reference
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    ckd_top dut (.i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_por(por), .i_brown_out(bod),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .o_sys_clk_en(sys_en), .o_timer_tick(tick), .o_core_rst_b(core_rst_b),
        .o_pc_reset_value(pc), .o_pin_pullup_en(pull), .o_pin_dir_out(dir),
        .i_xaddr(xaddr), .o_xaddr_retained(retained), .o_deep_sleep(deep), .o_rc_cal(rc_cal));

    ckd_periph_model u_periph (.i_ref_clk(ref_clk), .i_core_rst_b(core_rst_b), .i_tick(tick),
        .i_sys_en(sys_en), .o_ticks(ticks), .o_cycles(cycles), .o_resets(resets));

    task report_and_stop;
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    task chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s exp %h got %h", name, exp, got);
        end
    endtask : chk_val

    task reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
        if (a inside {ckd_pkg::OFF_CLK_CTRL, ckd_pkg::OFF_RCCAL, ckd_pkg::OFF_SLEEP}) begin
            mdl[a] = int'(d);
        end
    endtask : reg_wr

    // read one register and compare with the model
    task chk_reg(input logic [3:0] a);
        @(posedge ref_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        @(negedge ref_clk);
        rd_val = rdata;
        chk_val("rdata", 16'(mdl[a]), {8'h00, rd_val});
    endtask : chk_reg

    task reset_model(input int cause);
        foreach (mdl[i]) mdl[i] = 0;
        mdl[0] = int'({2'h0, ckd_pkg::TICK_RST, ckd_pkg::CLK_RST});
        mdl[1] = cause * 16 + int'(ckd_pkg::CLK_RST);
        mdl[5] = int'(ckd_pkg::RCCAL_RST);
    endtask : reset_model

    task after_reset;
        chk_val("pc", ckd_pkg::PC_RST, pc);
        chk_val("pullup", 16'h00FC, {8'h00, pull});
        chk_val("dir", 16'h0000, {8'h00, dir});
        chk_val("rc_cal", {8'h00, ckd_pkg::RCCAL_RST}, {8'h00, rc_cal});
        chk_reg(ckd_pkg::OFF_CLK_CTRL);
        chk_reg(ckd_pkg::OFF_STATUS);
        chk_reg(ckd_pkg::OFF_RCCAL);
        repeat (8) @(posedge ref_clk);
        chk_reg(ckd_pkg::OFF_WDT_LO);
    endtask : after_reset

    // pin, power-on or brown-out reset, then the state it leaves
    task hit_reset(input int src, input int cause);
        int n0;
        n0 = resets;
        @(posedge ref_clk);
        rst_b <= (src != 0);
        por <= (src == 1);
        bod <= (src == 2);
        repeat (3) @(posedge ref_clk);
        chk_val("core_rst_b", 16'h0000, {15'h0, core_rst_b});
        rst_b <= 1'b1;
        por <= 1'b0;
        bod <= 1'b0;
        repeat (20) @(posedge ref_clk);
        chk_val("resets", 16'(n0 + 1), 16'(resets));
        reset_model(cause);
        after_reset;
    endtask : hit_reset

    // count tick and system enables over a 256 cycle window
    task rate(input int ck, input int tk);
        int t0, c0;
        reg_wr(ckd_pkg::OFF_CLK_CTRL, {2'h0, 3'(tk), 3'(ck)});
        repeat (300) @(posedge ref_clk);
        t0 = ticks;
        c0 = cycles;
        repeat (256) @(posedge ref_clk);
        chk_val("ticks", 16'(256 >> tk), 16'(ticks - t0));
        chk_val("sys_en", 16'(256 >> ck), 16'(cycles - c0));
    endtask : rate

    task sleep_cycle(input logic [7:0] mode);
        reg_wr(ckd_pkg::OFF_WDT_CTRL, 8'h01);
        reg_wr(ckd_pkg::OFF_RCCAL, 8'($urandom));
        repeat (50) @(posedge ref_clk);
        reg_wr(ckd_pkg::OFF_SLEEP, mode);
        @(negedge ref_clk);
        chk_val("deep", 16'h0001, {15'h0, deep});
        chk_reg(ckd_pkg::OFF_WDT_LO);
        chk_reg(ckd_pkg::OFF_WDT_HI);
        chk_reg(ckd_pkg::OFF_RCCAL);
        chk_reg(ckd_pkg::OFF_CLK_CTRL);
        chk_reg(ckd_pkg::OFF_SLEEP);
        reg_wr(ckd_pkg::OFF_SLEEP, 8'h00);
        mdl[5] = int'(ckd_pkg::RCCAL_RST);
        @(negedge ref_clk);
        chk_val("deep", 16'h0000, {15'h0, deep});
        chk_val("rc_cal", {8'h00, ckd_pkg::RCCAL_RST}, {8'h00, rc_cal});
        chk_reg(ckd_pkg::OFF_RCCAL);
    endtask : sleep_cycle

    initial begin
        logic [15:0] x;
        int n0;
        static logic [15:0] bnd [8] = '{16'hEFFF, 16'hF000, 16'hFDA1, 16'hFDA2,
            16'hFEFF, 16'hFF00, 16'hFFFF, 16'h0000};
        {rst_b, por, bod, wr, rd} = 5'h00;
        addr = 4'h0;
        wdata = 8'h00;
        xaddr = 16'h0000;
        miscompares = 0;
        n_tests = 0;
        void'($urandom(24));
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (20) @(posedge ref_clk);
        reset_model(1);
        after_reset;
        // tick sweep under the fastest system clock, then system sweep
        for (int k = 0; k < 8; k++) rate(0, k);
        for (int k = 0; k < 8; k++) rate(k, 7);
        // retention window, edges first then random upper addresses
        for (int i = 0; i < 48; i++) begin
            x = (i < 8) ? bnd[i] : (16'($urandom) | 16'hE000);
            @(posedge ref_clk);
            xaddr <= x;
            @(negedge ref_clk);
            chk_val("retained", 16'(x >= ckd_pkg::RET_LO && !(x >= ckd_pkg::LOST_LO
                && x <= ckd_pkg::LOST_HI)), {15'h0, retained});
        end
        // unmapped places read zero and ignore writes
        for (int a = 7; a < 16; a++) begin
            reg_wr(4'(a), 8'hFF);
            chk_reg(4'(a));
        end
        sleep_cycle(8'h01);
        sleep_cycle(8'h02);
        // watchdog left running must time out and reset the core
        n0 = resets;
        for (int i = 0; i < 34000 && resets == n0; i++) @(posedge ref_clk);
        chk_val("wdt_reset", 16'(n0 + 1), 16'(resets));
        repeat (20) @(posedge ref_clk);
        reset_model(2);
        after_reset;
        hit_reset(0, 1);
        hit_reset(1, 0);
        hit_reset(2, 0);
        report_and_stop;
    end
endmodule : clock_divider_tick_and_reset_tb_top
